// [rtl/its_pkg.sv]
// register map, field positions and reset values of the two-wire slave engine
`default_nettype none
package its_pkg;
    // byte offsets on the register bus
    localparam logic [11:0] OFF_DATA = 12'h000;
    localparam logic [11:0] OFF_ADDR = 12'h004;
    localparam logic [11:0] OFF_CTRL0 = 12'h008;
    localparam logic [11:0] OFF_CTRL1 = 12'h00c;
    localparam logic [11:0] OFF_TOC = 12'h010;
    // serial_control_1 fields
    localparam int C1_BUSY = 6;
    localparam int C1_MATCH = 5;
    localparam int C1_TXMODE = 4;
    localparam int C1_TRANSMIT_ACK_BIT = 3;
    localparam int C1_DIR = 2;
    localparam int C1_RECEIVED_ACK_FLAG = 0;
    localparam logic [7:0] C1_RESET = 8'h01;
    localparam logic [7:0] C1_WMASK = 8'h18;
    // serial_control_0 fields
    localparam int C0_EN = 1;
    localparam logic [7:0] C0_RESET = 8'h00;
    // bus_timeout_control fields
    localparam int TO_EN = 7;
    localparam int TO_FLAG = 6;
    localparam logic [7:0] TOC_RESET = 8'h00;
    // timing
    localparam int CLK_HZ = 20000000;
    localparam int LS_CLK_HZ = 32768;
    localparam int LS_DIV = 32;
    // main clocks per low-speed tick, rounded down
    localparam int LS_TICK_CYCLES = CLK_HZ / LS_CLK_HZ;
    localparam logic [7:0] SLV_ADDR_RESET = 8'h00;
endpackage
`default_nettype wire

// [rtl/its_i2c_slave.sv]
// two-wire bus slave engine with inactivity time-out behind an APB slave
//
// Local design decisions: register access over APB and the placing of the registers.
`default_nettype none
// Function
// - start is sda falling while scl high
// - start sets bus busy flag
// - shift seven address bits msb first, compare
// - match sets match flag and interrupt
// - eighth bit stored as direction flag
// - acknowledge matched address low on ninth clock
// - direction one means slave transmits
// - software sets transmit mode from direction
// - hold scl low until data serviced
// - software tests match flag for source
// - eight bit bytes msb first
// - receiver acknowledges low after each byte
// - receive ack level from transmit ack bit
// - bytes pass through serial data register
// - record master ack, release on nack
// - timeout starts on match, clears on scl fall
// - timeout stops counter, clears enable, sets flag
// - timeout resets engine and control 1
// - period is (select+1) times 32 slow ticks
// - software clears timeout flag, reset zero
module its_i2c_slave #(
    parameter int TICK_CYCLES = its_pkg::LS_TICK_CYCLES
) (
    input wire logic MCLK_I,
    input wire logic RST_B_I,
    input wire logic CE_I,
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic PWRITE_I,
    input wire logic [11:0] PADDR_I,
    input wire logic [31:0] PWDATA_I,
    output logic [31:0] PRDATA_O,
    output logic PREADY_O,
    output logic PSLVERR_O,
    input wire logic SCL_I,
    output logic SCL_O,
    output logic SCL_OE_O,
    input wire logic SDA_I,
    output logic SDA_O,
    output logic SDA_OE_O,
    output logic IRQ_O
);
    typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_ACK, ST_RX, ST_TX, ST_MACK, ST_WAIT}
        its_state_e;

    its_state_e state_reg;
    logic [2:0] scl_sync_reg;
    logic [2:0] sda_sync_reg;
    logic scl_reg;
    logic sda_reg;
    logic [7:0] data_reg;
    logic [7:0] addr_reg;
    logic [7:0] ctrl0_reg;
    logic [7:0] ctrl1_reg;
    logic [7:0] toc_reg;
    logic [7:0] shift_reg;
    logic [3:0] bit_cnt_reg;
    logic stretch_reg;
    logic ack_drive_reg;
    logic irq_reg;
    logic [31:0] prdata_reg;
    logic pready_reg;
    logic sda_oe_reg;
    logic scl_oe_reg;
    logic scl_hold_reg;
    logic to_run_reg;
    logic [15:0] tick_cnt_reg;
    logic [4:0] div_cnt_reg;
    logic [6:0] period_cnt_reg;

    logic scl_now;
    logic sda_now;
    logic scl_rise;
    logic scl_fall;
    logic start_det;
    logic stop_det;
    logic wr_acc;
    logic rd_acc;
    logic time_out;
    logic ls_tick;
    logic data_serviced;

    function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
        hit = (a[11:2] == off[11:2]);
    endfunction

    // a change counts only once the second and third stages agree
    always_ff @(posedge MCLK_I) begin
        if (!RST_B_I) begin
            scl_sync_reg <= 3'h7;
            sda_sync_reg <= 3'h7;
            scl_reg <= 1'b1;
            sda_reg <= 1'b1;
        end else if (CE_I) begin
            scl_sync_reg <= {scl_sync_reg[1:0], SCL_I};
            sda_sync_reg <= {sda_sync_reg[1:0], SDA_I};
            if (scl_sync_reg[1] == scl_sync_reg[2]) begin
                scl_reg <= scl_sync_reg[2];
            end
            if (sda_sync_reg[1] == sda_sync_reg[2]) begin
                sda_reg <= sda_sync_reg[2];
            end
        end
    end

    assign scl_now = (scl_sync_reg[1] == scl_sync_reg[2]) ? scl_sync_reg[2] : scl_reg;
    assign sda_now = (sda_sync_reg[1] == sda_sync_reg[2]) ? sda_sync_reg[2] : sda_reg;
    assign scl_rise = scl_now && !scl_reg;
    assign scl_fall = !scl_now && scl_reg;
    assign start_det = scl_now && scl_reg && sda_reg && !sda_now;
    assign stop_det = scl_now && scl_reg && !sda_reg && sda_now;

    assign wr_acc = PSEL_I && PENABLE_I && PWRITE_I && pready_reg;
    assign rd_acc = PSEL_I && PENABLE_I && !PWRITE_I && pready_reg;
    // a write (transmit) or a dummy read (receive) releases the stretch
    assign data_serviced = (wr_acc || rd_acc) && hit(PADDR_I, its_pkg::OFF_DATA);

    // apb slave: one wait state, answer in the second access cycle
    always_ff @(posedge MCLK_I) begin
        if (!RST_B_I) begin
            pready_reg <= 1'b0;
            prdata_reg <= 32'h0;
        end else if (CE_I) begin
            pready_reg <= PSEL_I && PENABLE_I && !pready_reg;
            if (PSEL_I && PENABLE_I && !PWRITE_I && !pready_reg) begin
                prdata_reg <= 32'h0;
                if (hit(PADDR_I, its_pkg::OFF_DATA)) begin
                    prdata_reg <= {24'h0, data_reg};
                end else if (hit(PADDR_I, its_pkg::OFF_ADDR)) begin
                    prdata_reg <= {24'h0, addr_reg};
                end else if (hit(PADDR_I, its_pkg::OFF_CTRL0)) begin
                    prdata_reg <= {24'h0, ctrl0_reg};
                end else if (hit(PADDR_I, its_pkg::OFF_CTRL1)) begin
                    prdata_reg <= {24'h0, ctrl1_reg};
                end else if (hit(PADDR_I, its_pkg::OFF_TOC)) begin
                    prdata_reg <= {24'h0, toc_reg};
                end
            end
        end
    end

    always_ff @(posedge MCLK_I) begin
        if (!RST_B_I) begin
            addr_reg <= its_pkg::SLV_ADDR_RESET;
            ctrl0_reg <= its_pkg::C0_RESET;
        end else if (CE_I && wr_acc) begin
            // address and control 0 survive a time-out
            if (hit(PADDR_I, its_pkg::OFF_ADDR)) begin
                addr_reg <= {PWDATA_I[7:1], 1'b0};
            end
            if (hit(PADDR_I, its_pkg::OFF_CTRL0)) begin
                ctrl0_reg <= PWDATA_I[7:0];
            end
        end
    end

    // time-out prescaler: main clock -> slow tick -> slow/32
    assign ls_tick = (tick_cnt_reg == 16'(TICK_CYCLES - 1));
    assign time_out = to_run_reg && toc_reg[its_pkg::TO_EN] && ls_tick
        && (div_cnt_reg == 5'(its_pkg::LS_DIV - 1))
        && (period_cnt_reg == {1'b0, toc_reg[5:0]});

    always_ff @(posedge MCLK_I) begin
        if (!RST_B_I) begin
            to_run_reg <= 1'b0;
            tick_cnt_reg <= 16'h0;
            div_cnt_reg <= 5'h0;
            period_cnt_reg <= 7'h0;
        end else if (CE_I) begin
            tick_cnt_reg <= ls_tick ? 16'h0 : tick_cnt_reg + 16'h1;
            if (time_out || stop_det) begin
                to_run_reg <= 1'b0;
            end else if (state_reg == ST_ADDR && bit_cnt_reg == 4'h7 && scl_rise
                         && shift_reg[6:0] == addr_reg[7:1]) begin
                to_run_reg <= 1'b1;
            end
            if (!to_run_reg || scl_fall) begin
                div_cnt_reg <= 5'h0;
                period_cnt_reg <= 7'h0;
            end else if (ls_tick) begin
                div_cnt_reg <= div_cnt_reg + 5'h1;
                if (div_cnt_reg == 5'(its_pkg::LS_DIV - 1)) begin
                    period_cnt_reg <= period_cnt_reg + 7'h1;
                end
            end
        end
    end

    always_ff @(posedge MCLK_I) begin
        if (!RST_B_I) begin
            toc_reg <= its_pkg::TOC_RESET;
        end else if (CE_I) begin
            if (wr_acc && hit(PADDR_I, its_pkg::OFF_TOC)) begin
                toc_reg <= PWDATA_I[7:0];
            end
            if (time_out) begin
                toc_reg[its_pkg::TO_EN] <= 1'b0;
                toc_reg[its_pkg::TO_FLAG] <= 1'b1; // set wins over clear
            end
        end
    end

    // protocol engine
    always_ff @(posedge MCLK_I) begin
        if (!RST_B_I || (CE_I && time_out)) begin
            state_reg <= ST_IDLE;
            ctrl1_reg <= its_pkg::C1_RESET;
            shift_reg <= 8'h0;
            bit_cnt_reg <= 4'h0;
            stretch_reg <= 1'b0;
            ack_drive_reg <= 1'b0;
            irq_reg <= !RST_B_I ? 1'b0 : 1'b1;
            if (!RST_B_I) begin
                data_reg <= 8'h0;
            end
        end else if (CE_I) begin
            irq_reg <= 1'b0;
            if (wr_acc && hit(PADDR_I, its_pkg::OFF_CTRL1)) begin
                // software writes mode and ack bits only
                ctrl1_reg <= (ctrl1_reg & ~its_pkg::C1_WMASK)
                    | (PWDATA_I[7:0] & its_pkg::C1_WMASK);
            end
            if (wr_acc && hit(PADDR_I, its_pkg::OFF_DATA)) begin
                data_reg <= PWDATA_I[7:0];
            end
            if (data_serviced) begin
                stretch_reg <= 1'b0;
                ctrl1_reg[its_pkg::C1_MATCH] <= 1'b0;
            end
            if (ctrl0_reg[its_pkg::C0_EN] == 1'b0) begin
                state_reg <= ST_IDLE;
            end else if (start_det) begin
                ctrl1_reg[its_pkg::C1_BUSY] <= 1'b1;
                state_reg <= ST_ADDR;
                bit_cnt_reg <= 4'h0;
                ack_drive_reg <= 1'b0;
                stretch_reg <= 1'b0;
            end else if (stop_det) begin
                ctrl1_reg[its_pkg::C1_BUSY] <= 1'b0;
                state_reg <= ST_IDLE;
                ack_drive_reg <= 1'b0;
                stretch_reg <= 1'b0;
            end else begin
                unique case (state_reg)
                    ST_IDLE: begin
                    end
                    ST_ADDR: begin
                        if (scl_rise) begin
                            shift_reg <= {shift_reg[6:0], sda_now};
                            bit_cnt_reg <= bit_cnt_reg + 4'h1;
                            if (bit_cnt_reg == 4'h7) begin
                                if (shift_reg[6:0] == addr_reg[7:1]) begin
                                    ctrl1_reg[its_pkg::C1_DIR] <= sda_now;
                                    ctrl1_reg[its_pkg::C1_MATCH] <= 1'b1;
                                    irq_reg <= 1'b1;
                                    state_reg <= ST_ACK;
                                end else begin
                                    state_reg <= ST_WAIT;
                                end
                            end
                        end
                    end
                    ST_ACK: begin
                        // low ack spans the ninth clock, then hold scl low
                        if (scl_fall && !ack_drive_reg) begin
                            ack_drive_reg <= 1'b1;
                        end else if (scl_fall && ack_drive_reg) begin
                            ack_drive_reg <= 1'b0;
                            stretch_reg <= 1'b1;
                            bit_cnt_reg <= 4'h0;
                            shift_reg <= data_reg;
                            state_reg <= ctrl1_reg[its_pkg::C1_DIR] ? ST_TX : ST_RX;
                        end
                    end
                    ST_RX: begin
                        if (!stretch_reg && scl_rise && bit_cnt_reg < 4'h8) begin
                            shift_reg <= {shift_reg[6:0], sda_now};
                            bit_cnt_reg <= bit_cnt_reg + 4'h1;
                        end
                        if (scl_fall && bit_cnt_reg == 4'h8) begin
                            data_reg <= shift_reg;
                            irq_reg <= 1'b1;
                            ack_drive_reg <= !ctrl1_reg[its_pkg::C1_TRANSMIT_ACK_BIT];
                            bit_cnt_reg <= 4'h9;
                        end else if (scl_fall && bit_cnt_reg == 4'h9) begin
                            ack_drive_reg <= 1'b0;
                            stretch_reg <= 1'b1; // wait for the read of the byte
                            bit_cnt_reg <= 4'h0;
                        end
                    end
                    ST_TX: begin
                        if (data_serviced && wr_acc) begin
                            shift_reg <= PWDATA_I[7:0];
                        end
                        if (!stretch_reg && scl_fall) begin
                            shift_reg <= {shift_reg[6:0], 1'b1};
                            bit_cnt_reg <= bit_cnt_reg + 4'h1;
                            if (bit_cnt_reg == 4'h7) begin
                                state_reg <= ST_MACK;
                            end
                        end
                    end
                    ST_MACK: begin
                        if (scl_rise) begin
                            ctrl1_reg[its_pkg::C1_RECEIVED_ACK_FLAG] <= sda_now;
                        end
                        if (scl_fall) begin
                            irq_reg <= 1'b1;
                            bit_cnt_reg <= 4'h0;
                            if (!ctrl1_reg[its_pkg::C1_RECEIVED_ACK_FLAG]) begin
                                stretch_reg <= 1'b1;
                                state_reg <= ST_TX;
                            end else begin
                                state_reg <= ST_WAIT;
                            end
                        end
                    end
                    ST_WAIT: begin
                    end
                endcase
            end
        end
    end

    // open-drain drive: only ever pull low, never generate a start
    always_ff @(posedge MCLK_I) begin
        if (!RST_B_I) begin
            sda_oe_reg <= 1'b0;
            scl_oe_reg <= 1'b0;
            scl_hold_reg <= 1'b0;
        end else if (CE_I) begin
            scl_hold_reg <= stretch_reg;
            sda_oe_reg <= ack_drive_reg
                || (state_reg == ST_TX && !stretch_reg && !shift_reg[7]);
            // hold the clock one cycle past the stretch so the first data bit settles first
            scl_oe_reg <= stretch_reg || scl_hold_reg;
        end
    end

    assign SDA_O = 1'b0;
    assign SCL_O = 1'b0;
    assign SDA_OE_O = sda_oe_reg;
    assign SCL_OE_O = scl_oe_reg;
    assign PRDATA_O = prdata_reg;
    assign PREADY_O = pready_reg;
    assign PSLVERR_O = 1'b0;
    assign IRQ_O = irq_reg;
endmodule
`default_nettype wire

// [verification/its_i2c_slave_assertions.sv]
// port-level checks of the two-wire slave engine
`default_nettype none
module its_i2c_slave_assertions (
    input wire logic MCLK_I,
    input wire logic RST_B_I,
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic [11:0] PADDR_I,
    input wire logic [31:0] PRDATA_O,
    input wire logic PREADY_O,
    input wire logic SCL_I,
    input wire logic SCL_O,
    input wire logic SCL_OE_O,
    input wire logic SDA_O,
    input wire logic SDA_OE_O,
    input wire logic IRQ_O
);
    default clocking @(posedge MCLK_I); endclocking
    default disable iff (!RST_B_I);
    property p_open_drain;
        !SCL_O && !SDA_O;
    endproperty
    a_open_drain: assert property (p_open_drain) else $error("pin driven high");
    // data may only move while the clock line is low
    property p_sda_stable;
        SCL_I && $past(SCL_I) |-> $stable(SDA_OE_O);
    endproperty
    a_sda_stable: assert property (p_sda_stable) else $error("data moved, clock high");
    property p_no_start;
        $changed(SDA_OE_O) |-> !SCL_I;
    endproperty
    a_no_start: assert property (p_no_start) else $error("slave made a bus condition");
    property p_stretch_low;
        $rose(SCL_OE_O) |-> !SCL_I;
    endproperty
    a_stretch_low: assert property (p_stretch_low) else $error("stretch began high");
    property p_release;
        PREADY_O && PSEL_I && PADDR_I == its_pkg::OFF_DATA && SCL_OE_O |-> ##[1:4] !SCL_OE_O;
    endproperty
    a_release: assert property (p_release) else $error("stretch kept after service");
    property p_ready;
        PSEL_I && PENABLE_I && !$past(PENABLE_I) |-> !PREADY_O ##1 PREADY_O;
    endproperty
    a_ready: assert property (p_ready) else $error("ready not after one wait");
    property p_rdata;
        PREADY_O |-> PRDATA_O[31:8] == 24'h0;
    endproperty
    a_rdata: assert property (p_rdata) else $error("upper read bits set");
    property p_irq_pulse;
        IRQ_O |=> !IRQ_O;
    endproperty
    a_irq_pulse: assert property (p_irq_pulse) else $error("interrupt longer than pulse");
endmodule
bind its_i2c_slave its_i2c_slave_assertions its_i2c_slave_assertions_inst (.MCLK_I(MCLK_I),
    .RST_B_I(RST_B_I), .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I), .PADDR_I(PADDR_I),
    .PRDATA_O(PRDATA_O), .PREADY_O(PREADY_O), .SCL_I(SCL_I), .SCL_O(SCL_O),
    .SCL_OE_O(SCL_OE_O), .SDA_O(SDA_O), .SDA_OE_O(SDA_OE_O), .IRQ_O(IRQ_O));
`default_nettype wire

// [verification/its_bus_master.sv]
// behavioural two-wire bus master on pulled-up clock and data lines
`default_nettype none
module its_bus_master (
    input wire logic clk_i,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic scl_low_o,
    output logic sda_low_o
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        scl_low_o = 1'b0;
        sda_low_o = 1'b0;
    end
    task automatic hp();
        repeat (10) @(posedge clk_i);
    endtask
    // only this side opens a frame
    task automatic start();
        sda_low_o <= 1'b1;
        hp();
        scl_low_o <= 1'b1;
        hp();
    endtask
    // the slave may hold the clock low; no bound here, the bench watchdog ends a hang
    task automatic release_scl();
        scl_low_o <= 1'b0;
        do @(posedge clk_i); while (scl_i !== 1'b1);
        hp();
    endtask
    task automatic put_bit(input logic b, output logic r);
        sda_low_o <= !b;
        hp();
        release_scl();
        r = sda_i;
        scl_low_o <= 1'b1;
        hp();
    endtask
    task automatic xfer(input logic [7:0] d, input logic ack_in, output logic [7:0] q,
            output logic ack);
        for (int i = 7; i >= 0; i--) put_bit(d[i], q[i]);
        put_bit(ack_in, ack);
    endtask
    // also used to end a frame whose address went unanswered
    task automatic stop();
        sda_low_o <= 1'b1;
        hp();
        release_scl();
        sda_low_o <= 1'b0;
        hp();
    endtask
endmodule
`default_nettype wire

// [verification/testbench.sv]
// bench: apb software side of the slave engine against a bus master model
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk, rst_b, psel, penable, pwrite, pready, scl_oe, sda_oe, scl_o, sda_o, irq;
    logic m_scl, m_sda, a;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [7:0] q;
    wire logic scl_w, sda_w;
    int err_count, total_checks, dt;
    time t_fall;
    // pulled-up lines: low while any party enables its driver
    assign scl_w = !(m_scl || (scl_oe && !scl_o));
    assign sda_w = !(m_sda || (sda_oe && !sda_o));
    its_i2c_slave #(.TICK_CYCLES(2)) its_i2c_slave_inst (.MCLK_I(clk), .RST_B_I(rst_b),
        .CE_I(1'b1), .PSEL_I(psel), .PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr),
        .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(),
        .SCL_I(scl_w), .SCL_O(scl_o), .SCL_OE_O(scl_oe), .SDA_I(sda_w), .SDA_O(sda_o),
        .SDA_OE_O(sda_oe), .IRQ_O(irq));
    its_bus_master its_bus_master_inst (.clk_i(clk), .scl_i(scl_w), .sda_i(sda_w),
        .scl_low_o(m_scl), .sda_low_o(m_sda));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_count++;
            $display("Error at %0t ns: got %h, expected %h", $time, got, exp);
        end
    endtask
    // one apb transfer; a read is compared under mask m when m is non-zero
    task automatic acc(input logic w, input logic [11:0] ad, input logic [7:0] d,
            input logic [7:0] m, input logic [7:0] e);
        int n;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= ad;
        pwdata <= {24'h0, d};
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) begin
            err_count++;
            $display("Error at %0t ns: no ready", $time);
        end
        if (m != 8'h00) chk(prdata[7:0] & m, e);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    // waits for an interrupt pulse (k 0), a stretch (k 1) or its end (k 2)
    task automatic wt(input int k);
        int n;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while ((k == 0 ? irq : scl_oe) !== (k != 2) && n < 20000);
        if (n >= 20000) begin
            err_count++;
            $display("Error at %0t ns: wait limit", $time);
        end
    endtask
    task automatic t_rx();
        its_bus_master_inst.start();
        its_bus_master_inst.xfer(8'h5c, 1'b1, q, a);
        chk({7'h0, a}, 8'h01);
        its_bus_master_inst.stop();
        fork
            begin
                its_bus_master_inst.start();
                its_bus_master_inst.xfer(8'h5a, 1'b1, q, a);
                chk({7'h0, a}, 8'h00);
                its_bus_master_inst.xfer(8'ha5, 1'b1, q, a);
                chk({7'h0, a}, 8'h00);
                its_bus_master_inst.xfer(8'h3c, 1'b1, q, a);
                chk({7'h0, a}, 8'h01);
                its_bus_master_inst.stop();
            end
            begin
                wt(0);
                acc(1'b0, its_pkg::OFF_CTRL1, 8'h00, 8'h64, 8'h60);
                acc(1'b1, its_pkg::OFF_CTRL1, 8'h00, 8'h00, 8'h00);
                wt(1);
                acc(1'b0, its_pkg::OFF_DATA, 8'h00, 8'h00, 8'h00);
                wt(0);
                acc(1'b0, its_pkg::OFF_CTRL1, 8'h00, 8'h20, 8'h00);
                acc(1'b1, its_pkg::OFF_CTRL1, 8'h08, 8'h00, 8'h00);
                wt(1);
                acc(1'b0, its_pkg::OFF_DATA, 8'h00, 8'hff, 8'ha5);
                wt(0);
                wt(1);
                acc(1'b0, its_pkg::OFF_DATA, 8'h00, 8'hff, 8'h3c);
            end
        join
        acc(1'b0, its_pkg::OFF_CTRL1, 8'h00, 8'h40, 8'h00);
        $display("receive test done");
    endtask
    task automatic t_tx();
        fork
            begin
                its_bus_master_inst.start();
                its_bus_master_inst.xfer(8'h5b, 1'b1, q, a);
                chk({7'h0, a}, 8'h00);
                its_bus_master_inst.xfer(8'hff, 1'b0, q, a);
                chk(q, 8'h96);
                its_bus_master_inst.xfer(8'hff, 1'b1, q, a);
                chk(q, 8'h41);
                its_bus_master_inst.stop();
            end
            begin
                wt(0);
                acc(1'b0, its_pkg::OFF_CTRL1, 8'h00, 8'h64, 8'h64);
                acc(1'b1, its_pkg::OFF_CTRL1, 8'h10, 8'h00, 8'h00);
                wt(1);
                acc(1'b1, its_pkg::OFF_DATA, 8'h96, 8'h00, 8'h00);
                wt(2);
                wt(1);
                acc(1'b0, its_pkg::OFF_CTRL1, 8'h00, 8'h01, 8'h00);
                acc(1'b1, its_pkg::OFF_DATA, 8'h41, 8'h00, 8'h00);
            end
        join
        acc(1'b0, its_pkg::OFF_CTRL1, 8'h00, 8'h01, 8'h01);
        $display("transmit test done");
    endtask
    // period select 1 with two clocks a slow tick: 128 clocks after the last clock fall
    task automatic t_to();
        acc(1'b1, its_pkg::OFF_TOC, 8'h81, 8'h00, 8'h00);
        fork
            begin
                its_bus_master_inst.start();
                its_bus_master_inst.xfer(8'h5a, 1'b1, q, a);
                its_bus_master_inst.stop();
            end
            begin
                wt(0);
                wt(0);
                dt = int'(($time - t_fall) / 64'd50);
                chk({7'h0, dt >= 128 && dt <= 140}, 8'h01);
                acc(1'b0, its_pkg::OFF_TOC, 8'h00, 8'hff, 8'h41);
                acc(1'b0, its_pkg::OFF_CTRL1, 8'h00, 8'hff, 8'h01);
                acc(1'b0, its_pkg::OFF_ADDR, 8'h00, 8'hff, 8'h5a);
            end
        join
        acc(1'b1, its_pkg::OFF_TOC, 8'h01, 8'h00, 8'h00);
        acc(1'b0, its_pkg::OFF_TOC, 8'h00, 8'hff, 8'h01);
        $display("time-out test done");
    endtask
    task automatic report_and_stop();
        $display("checks %0d, mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    always @(negedge scl_w) t_fall = $time;
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    initial begin
        repeat (40000) @(posedge clk);
        $display("Error at %0t ns: watchdog expired", $time);
        err_count++;
        report_and_stop();
    end
    initial begin
        {rst_b, psel, penable, pwrite, paddr, pwdata} = '0;
        err_count = 0;
        total_checks = 0;
        repeat (8) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        acc(1'b0, its_pkg::OFF_CTRL1, 8'h00, 8'hff, 8'h01);
        acc(1'b0, its_pkg::OFF_TOC, 8'h00, 8'hff, 8'h00);
        acc(1'b1, 12'h014, 8'h55, 8'h00, 8'h00);
        acc(1'b0, 12'h014, 8'h00, 8'hff, 8'h00);
        acc(1'b1, its_pkg::OFF_ADDR, 8'h5a, 8'h00, 8'h00);
        acc(1'b1, its_pkg::OFF_CTRL0, 8'h02, 8'h00, 8'h00);
        t_rx();
        t_tx();
        t_to();
        report_and_stop();
    end
endmodule
`default_nettype wire
